// file: pkg/bus_cycle_pkg.sv
// Package for the multiplexed external bus cycle block.
// Assumes a single 100 MHz core clock and synchronous active-low reset.
package bus_cycle_pkg;
    localparam int ADDR_W        = 20;
    localparam int DATA_W        = 8;
    localparam int MID_LO        = 8;
    localparam int MID_HI        = 15;
    localparam int UP_LO         = 16;
    localparam int UP_HI         = 19;
    localparam int SEG_W         = 2;

    // Bus status codes (three lines, passive is all ones)
    localparam logic [2:0] ST_IRQ_ACK = 3'h0;
    localparam logic [2:0] ST_IO_RD   = 3'h1;
    localparam logic [2:0] ST_IO_WR   = 3'h2;
    localparam logic [2:0] ST_HALT    = 3'h3;
    localparam logic [2:0] ST_CODE    = 3'h4;
    localparam logic [2:0] ST_MEM_RD  = 3'h5;
    localparam logic [2:0] ST_MEM_WR  = 3'h6;
    localparam logic [2:0] ST_PASSIVE = 3'h7;

    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [7:0]        MID_ZERO  = 8'h00;
    localparam logic [3:0]        UP_ZERO   = 4'h0;

    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_ADDR  = 6'b000010,
        S_T2    = 6'b000100,
        S_T3    = 6'b001000,
        S_WAIT  = 6'b010000,
        S_FINAL = 6'b100000
    } cyc_state_t;

    // Kind of cycle requested by the core side
    typedef enum logic [1:0] {
        K_READ    = 2'h0,
        K_WRITE   = 2'h1,
        K_IRQ_ACK = 2'h2
    } cyc_kind_t;

    typedef struct packed {
        cyc_kind_t          kind;
        logic               io;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  wdata;
        logic [SEG_W-1:0]   seg;
        logic               ie_flag;
    } bus_req_t;
endpackage

// file: design/input_sync.sv
// Two-stage synchroniser for one asynchronous level input.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/1ps
module input_sync
    import bus_cycle_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_rst_b,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta;

    // [R6] Two-flop recognition
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            meta   <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// file: design/muxed_bus_cycle.sv
// External bus cycle engine: muxed low byte, middle address, wait states.
// Assumes core requests are held until o_req_ready; hold is synchronised here.
//
// Function
// [R1] Sample ready in T2, T3, waits; insert waits
// [R2] Two back-to-back acknowledge cycles
// [R3] Low lines floated during acknowledge cycles
// [R4] External cascade address held between acknowledges
// [R5] Status passive in state before final
// [R6] Async input recognised within bounded clocks
// [R7] Low lines: address first, data after
// [R8] Float low and middle lines in acknowledge/hold
// [R9] Middle address held whole cycle
// [R10] Coprocessor drives only within granted interval
// [R11] Upper lines address, then status bits
// [R12] Latch strobe positive pulse, never floated
// [R13] Read strobe low on reads, float in hold
// [R14] Device raises ready when able
// [R15] Four states, waits between third and final
`timescale 1ns/1ps
module muxed_bus_cycle
    import bus_cycle_pkg::*;
(
    input  wire logic               i_core_clk,
    input  wire logic               i_rst_b,
    input  wire logic               i_req_valid,
    input  wire bus_req_t           i_req,
    output logic                    o_req_ready,
    output logic [DATA_W-1:0]       o_rdata,
    output logic                    o_rdata_valid,
    input  wire logic               i_ready,
    input  wire logic               i_hold,
    output logic                    o_hold_grant,
    input  wire logic [DATA_W-1:0]  i_shared_addr_data_low,
    output logic [DATA_W-1:0]       o_shared_addr_data_low,
    output logic                    o_shared_addr_data_low_oe,
    output logic [7:0]              o_mid_address_out,
    output logic                    o_mid_address_out_oe,
    output logic [3:0]              o_upper_addr_status,
    output logic                    o_upper_addr_status_oe,
    output logic [2:0]              o_status,
    output logic                    o_addr_latch,
    output logic                    o_read_strobe_b,
    output logic                    o_read_strobe_oe,
    output logic                    o_write_strobe_b,
    output logic                    o_irq_ack_strobe_b
);
    cyc_state_t state;
    cyc_state_t next_state;
    bus_req_t   cur;
    logic       second_ack;
    logic       hold_sync;
    logic       is_ack;
    logic       is_rd;
    logic       done_ack_pair;
    logic       rdy_seen;

    input_sync u_hold_sync (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_async    (i_hold),
        .o_sync     (hold_sync)
    );

    assign is_ack        = (cur.kind == K_IRQ_ACK);
    assign is_rd         = (cur.kind == K_READ);
    assign done_ack_pair = is_ack && !second_ack;

    // [R15] Four-state sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            S_IDLE: begin
                if (second_ack)
                    next_state = S_ADDR;
                // Finished request still held while ready pulses: not taken again
                else if (i_req_valid && !o_req_ready && !hold_sync && !o_hold_grant)
                    next_state = S_ADDR;
            end
            S_ADDR:  next_state = S_T2;
            S_T2:    next_state = S_T3;
            // [R1] Ready seen one state earlier decides exit
            S_T3:    next_state = rdy_seen ? S_FINAL : S_WAIT;
            S_WAIT:  next_state = rdy_seen ? S_FINAL : S_WAIT;
            S_FINAL: next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b)
            state <= S_IDLE;
        else
            state <= next_state;
    end

    // [R1] Ready taken at end of T2, T3, waits
    // One state of lookahead lets status go passive before final
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b)
            rdy_seen <= 1'b0;
        else
            rdy_seen <= i_ready && (state == S_T2 || state == S_T3 || state == S_WAIT);
    end

    // Request capture; second acknowledge replays the first
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            cur        <= '0;
            second_ack <= 1'b0;
        end else if (state == S_IDLE && next_state == S_ADDR && !second_ack) begin
            cur <= i_req;
        end else if (state == S_FINAL) begin
            // [R2] Chain second acknowledge
            second_ack <= done_ack_pair;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b)
            o_req_ready <= 1'b0;
        else
            o_req_ready <= (state == S_FINAL) && !done_ack_pair;
    end

    // Hold grant only between cycles, never inside an acknowledge pair
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b)
            o_hold_grant <= 1'b0;
        else if (!hold_sync)
            o_hold_grant <= 1'b0;
        else if (next_state == S_IDLE && !(state == S_FINAL && done_ack_pair) && !second_ack)
            o_hold_grant <= 1'b1;
    end

    // Pin drive registered from next state so outputs match state
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_shared_addr_data_low    <= DATA_ZERO;
            o_shared_addr_data_low_oe <= 1'b0;
            o_mid_address_out         <= MID_ZERO;
            o_mid_address_out_oe      <= 1'b0;
            o_upper_addr_status       <= UP_ZERO;
            o_upper_addr_status_oe    <= 1'b0;
            o_status                  <= ST_PASSIVE;
            o_addr_latch              <= 1'b0;
            o_read_strobe_b           <= 1'b1;
            o_read_strobe_oe          <= 1'b1;
            o_write_strobe_b          <= 1'b1;
            o_irq_ack_strobe_b        <= 1'b1;
        end else begin
            o_addr_latch       <= 1'b0;
            o_read_strobe_b    <= 1'b1;
            o_write_strobe_b   <= 1'b1;
            o_irq_ack_strobe_b <= 1'b1;
            o_status           <= ST_PASSIVE;
            o_shared_addr_data_low_oe <= 1'b0;
            o_mid_address_out_oe      <= 1'b0;
            // [R13] Strobe floats in hold
            o_read_strobe_oe          <= !(hold_sync && next_state == S_IDLE);
            o_upper_addr_status_oe    <= !(hold_sync && next_state == S_IDLE);
            unique case (next_state)
                S_ADDR: begin
                    // [R12] Latch strobe in first state
                    o_addr_latch <= 1'b1;
                    o_status     <= second_ack ? ST_IRQ_ACK :
                                    (i_req.kind == K_IRQ_ACK) ? ST_IRQ_ACK :
                                    (i_req.kind == K_WRITE) ?
                                        (i_req.io ? ST_IO_WR : ST_MEM_WR) :
                                        (i_req.io ? ST_IO_RD : ST_MEM_RD);
                    // [R7] Address phase on low lines
                    o_shared_addr_data_low    <= i_req.addr[DATA_W-1:0];
                    o_shared_addr_data_low_oe <= !second_ack && i_req.kind != K_IRQ_ACK;
                    // [R9] Middle address driven
                    o_mid_address_out         <= i_req.addr[MID_HI:MID_LO];
                    o_mid_address_out_oe      <= !second_ack && i_req.kind != K_IRQ_ACK;
                    // [R11] Upper address, low for I/O
                    o_upper_addr_status <= i_req.io ? UP_ZERO : i_req.addr[UP_HI:UP_LO];
                    o_upper_addr_status_oe <= 1'b1;
                end
                S_T2, S_T3, S_WAIT: begin
                    // [R5] Ready seen: this is the state before final
                    o_status <= (next_state != S_T2 && i_ready) ? ST_PASSIVE :
                                (is_ack ? ST_IRQ_ACK : is_rd ?
                                    (cur.io ? ST_IO_RD : ST_MEM_RD) :
                                    (cur.io ? ST_IO_WR : ST_MEM_WR));
                    // [R8] Float during acknowledge
                    o_mid_address_out_oe <= !is_ack;
                    // [R3] Low lines released for vector
                    o_shared_addr_data_low_oe <= !is_ack && !is_rd;
                    o_shared_addr_data_low    <= cur.wdata;
                    o_read_strobe_b    <= !is_rd;
                    o_write_strobe_b   <= !(cur.kind == K_WRITE);
                    o_irq_ack_strobe_b <= !is_ack;
                    o_upper_addr_status <= {1'b0, cur.ie_flag, cur.seg};
                end
                S_FINAL: begin
                    o_mid_address_out_oe      <= !is_ack;
                    o_shared_addr_data_low_oe <= !is_ack && !is_rd;
                    o_upper_addr_status       <= {1'b0, cur.ie_flag, cur.seg};
                end
                S_IDLE: begin
                end
                default: begin
                end
            endcase
        end
    end

    // Read data captured at the end of the ready-qualified state
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_rdata       <= DATA_ZERO;
            o_rdata_valid <= 1'b0;
        end else begin
            o_rdata_valid <= 1'b0;
            if ((state == S_T3 || state == S_WAIT) && rdy_seen && (is_rd || is_ack)) begin
                o_rdata       <= i_shared_addr_data_low;
                o_rdata_valid <= is_rd || second_ack;
            end
        end
    end

    // [R15] Wait state follows T3 while ready not seen
    property p_wait_order;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (state == S_T3 && !rdy_seen) |=> state == S_WAIT;
    endproperty
    a_wait_order: assert property (p_wait_order) else $error("no wait state"); // [R15]

    property p_t2_sample;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (state == S_T2 && !i_ready) |=> ##1 state == S_WAIT;
    endproperty
    a_t2_sample: assert property (p_t2_sample) else $error("ready in T2 ignored"); // [R1]

    property p_ready_exit;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        ((state == S_WAIT || state == S_T3) && rdy_seen) |=> state == S_FINAL;
    endproperty
    a_ready_exit: assert property (p_ready_exit) else $error("ready ignored"); // [R1]

    property p_seq;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        state == S_ADDR |=> state == S_T2 ##1 state == S_T3;
    endproperty
    a_seq: assert property (p_seq) else $error("bad state order"); // [R15]

    property p_ack_pair;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (state == S_FINAL && done_ack_pair) |=> ##1 (state == S_ADDR && second_ack);
    endproperty
    a_ack_pair: assert property (p_ack_pair) else $error("acks not back to back"); // [R2]

    property p_ack_float;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (!o_irq_ack_strobe_b) |-> !o_shared_addr_data_low_oe && !o_mid_address_out_oe;
    endproperty
    a_ack_float: assert property (p_ack_float) else $error("lines driven in ack"); // [R3]

    property p_hold_float;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        o_hold_grant |-> !o_shared_addr_data_low_oe && !o_mid_address_out_oe;
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("lines driven in hold"); // [R8]

    property p_latch_pulse;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        o_addr_latch |=> !o_addr_latch;
    endproperty
    a_latch_pulse: assert property (p_latch_pulse) else $error("latch not a pulse"); // [R12]

    property p_mid_stable;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (o_mid_address_out_oe && !o_addr_latch) |-> $stable(o_mid_address_out);
    endproperty
    a_mid_stable: assert property (p_mid_stable) else $error("mid address moved"); // [R9]

    property p_passive;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        state == S_FINAL |-> $past(o_status) == ST_PASSIVE && o_status == ST_PASSIVE;
    endproperty
    a_passive: assert property (p_passive) else $error("status not passive"); // [R5]
endmodule

// file: sim/bus_partner.sv
// Memory/IO/vector device model on the far side of the bus engine.
// Assumes strobes are active low and the engine enables its low lines.
`timescale 1ns/1ps
module bus_partner (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_rd_b,
    input  wire logic       i_ack_b,
    input  wire logic       i_wr_b,
    input  wire logic       i_drv_oe,
    input  wire logic [7:0] i_drv_data,
    input  wire logic [7:0] i_resp,
    input  wire logic [3:0] i_waits,
    output logic            o_ready,
    output logic [7:0]      o_bus
);
    logic [3:0] cnt;
    logic [7:0] last;
    logic [7:0] cascade;
    logic       pair_open;
    logic       prev_ack_b;
    wire        busy = !(i_rd_b && i_ack_b && i_wr_b);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b || !busy) begin
            cnt <= 4'h0;
        end else if (cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
        end
    end

    // Released lines show the inverse of their last value
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b)
            last <= 8'h00;
        else
            last <= o_bus;
    end

    // Cascade code held across the pair
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            cascade    <= 8'h00;
            pair_open  <= 1'b0;
            prev_ack_b <= 1'b1;
        end else begin
            prev_ack_b <= i_ack_b;
            if (prev_ack_b && !i_ack_b) begin
                pair_open <= !pair_open;
                if (!pair_open)
                    cascade <= i_resp;
            end
        end
    end

    assign o_ready = !busy || (cnt >= i_waits);

    always_comb begin
        if (i_drv_oe) begin
            o_bus = i_drv_data;
        end else if (!i_ack_b) begin
            o_bus = cascade;
        end else if (!i_rd_b) begin
            o_bus = i_resp;
        end else begin
            o_bus = ~last;
        end
    end
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the muxed bus cycle engine.
// Assumes the partner model answers reads and acknowledge cycles.
`timescale 1ns/1ps
module tb_top;
    import bus_cycle_pkg::*;
    logic i_core_clk = 0, i_rst_b = 0, i_req_valid = 0, i_hold = 0, rdy;
    bus_req_t i_req = '0;
    logic [7:0] bus, resp = 8'hA5;
    logic [3:0] waits = 4'h0;
    logic o_req_ready, o_rdata_valid, o_hold_grant, ad_oe, mid_oe, up_oe;
    logic o_addr_latch, rd_b, rd_oe, wr_b, ack_b, prev_ack = 1, prev_rdy = 1;
    logic [7:0] o_rdata, ad_out, mid;
    logic [3:0] up;
    logic [2:0] st, prev_st = 3'h7, exp_st;
    int n_errors = 0, samples_checked = 0, cyc = 0, n_ack, n_latch, lat0, lat3;

    always #5 i_core_clk = ~i_core_clk;

    muxed_bus_cycle DUT (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
        .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid), .i_ready(rdy),
        .i_hold(i_hold), .o_hold_grant(o_hold_grant), .i_shared_addr_data_low(bus),
        .o_shared_addr_data_low(ad_out), .o_shared_addr_data_low_oe(ad_oe),
        .o_mid_address_out(mid), .o_mid_address_out_oe(mid_oe),
        .o_upper_addr_status(up), .o_upper_addr_status_oe(up_oe), .o_status(st),
        .o_addr_latch(o_addr_latch), .o_read_strobe_b(rd_b), .o_read_strobe_oe(rd_oe),
        .o_write_strobe_b(wr_b), .o_irq_ack_strobe_b(ack_b));

    bus_partner u_partner (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_rd_b(rd_b),
        .i_ack_b(ack_b), .i_wr_b(wr_b), .i_drv_oe(ad_oe), .i_drv_data(ad_out),
        .i_resp(resp), .i_waits(waits), .o_ready(rdy), .o_bus(bus));

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Line checks made every cycle of a transfer
    always @(posedge i_core_clk) begin
        if (i_rst_b && i_req_valid) begin
            if (o_addr_latch) begin
                n_latch++;
                exp_st = i_req.io ? ST_IO_RD : ST_MEM_RD;
                if (i_req.kind == K_WRITE) exp_st = i_req.io ? ST_IO_WR : ST_MEM_WR;
                if (i_req.kind == K_IRQ_ACK) exp_st = ST_IRQ_ACK;
                chk(st, exp_st);
                if (i_req.kind != K_IRQ_ACK) begin
                    chk(ad_oe ? ad_out : 8'hXX, i_req.addr[7:0]);
                    chk(up, i_req.io ? 4'h0 : i_req.addr[19:16]);
                end
            end
            if (!rd_b || !wr_b) begin
                chk({mid_oe, mid}, {1'b1, i_req.addr[15:8]});
                chk(ad_oe, !wr_b);
            end
            if (!rd_b || !wr_b || !ack_b) chk(up, {1'b0, i_req.ie_flag, i_req.seg});
            if (!wr_b) chk(ad_out, i_req.wdata);
            if (!ack_b) chk({ad_oe, mid_oe}, 2'b00);
            if (prev_ack && !ack_b) n_ack++;
            // Passive after ready, while the strobe still stands
            if (st === ST_PASSIVE && prev_st !== ST_PASSIVE)
                chk({prev_rdy, rd_b & wr_b & ack_b}, 2'b10);
            if (o_rdata_valid && i_req.kind != K_WRITE) chk(o_rdata, resp);
        end
        prev_ack <= ack_b;
        prev_rdy <= rdy;
        prev_st <= st;
    end

    task automatic do_req(input cyc_kind_t k, input logic io, input logic [19:0] a,
                          input logic [3:0] w, output int lat);
        @(posedge i_core_clk);
        waits <= w;
        i_req <= '{kind: k, io: io, addr: a, wdata: ~a[7:0], seg: 2'h1, ie_flag: 1'b1};
        i_req_valid <= 1'b1;
        n_ack = 0;
        n_latch = 0;
        lat = 0;
        do begin
            @(posedge i_core_clk);
            lat++;
        end while (o_req_ready !== 1'b1 && lat < 200);
        chk(lat < 200, 1'b1);
        i_req_valid <= 1'b0;
    endtask

    task automatic test_reads_waits();
        do_req(K_READ, 1'b0, 20'hC3A5B, 4'h0, lat0);
        do_req(K_READ, 1'b0, 20'h5A4C1, 4'h3, lat3);
        // One wait state for each ready sample taken low
        chk(lat3 - lat0 == 3, 1'b1);
        chk(lat0 >= 5, 1'b1);
    endtask

    task automatic test_io_write_ack();
        do_req(K_WRITE, 1'b1, 20'hF1234, 4'h1, lat0);
        do_req(K_IRQ_ACK, 1'b0, 20'h00000, 4'h2, lat0);
        chk(n_ack, 2);
        chk(n_latch, 2);
    endtask

    task automatic test_hold();
        int i;
        @(posedge i_core_clk);
        i_hold <= 1'b1;
        for (i = 0; i < 20 && o_hold_grant !== 1'b1; i++) @(posedge i_core_clk);
        chk(i <= 4, 1'b1);
        chk({ad_oe, mid_oe, up_oe, rd_oe}, 4'h0);
        i_req <= '{kind: K_READ, io: 1'b0, addr: 20'h12345, wdata: 8'h00, seg: 2'h0,
                   ie_flag: 1'b0};
        i_req_valid <= 1'b1;
        n_latch = 0;
        repeat (10) @(posedge i_core_clk);
        chk(n_latch, 0);
        i_hold <= 1'b0;
        i_req_valid <= 1'b0;
        do_req(K_READ, 1'b0, 20'h12345, 4'h0, lat0);
        chk(rd_oe, 1'b1);
    endtask

    initial begin
        repeat (20) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        test_reads_waits();
        test_io_write_ack();
        test_hold();
        test_done();
    end

    // Whole run needs well under a thousand cycles
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end
endmodule
